// ---- crts_pkg.sv ----
// Purpose : shared constants for the clock reference and termination select block
// Assumes : 200 MHz system clock, 14 line channels
// Notes   : selection codes, reset values and a code-to-rate function; no register map (plain ports)
package crts_pkg;

  localparam int unsigned CRTS_NUM_CH        = 14;
  localparam int unsigned CRTS_CLK_HZ        = 200_000_000;

  // ----------------------------------------------------------------
  // input reference selection codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CRTS_REF_2048K_A = 4'h0,
    CRTS_REF_1544K_A = 4'h1,
    CRTS_REF_8K      = 4'h2,
    CRTS_REF_16K     = 4'h3,
    CRTS_REF_56K     = 4'h4,
    CRTS_REF_64K     = 4'h5,
    CRTS_REF_128K    = 4'h6,
    CRTS_REF_256K    = 4'h7,
    CRTS_REF_4096K   = 4'h8,
    CRTS_REF_3088K   = 4'h9,
    CRTS_REF_8192K   = 4'ha,
    CRTS_REF_6176K   = 4'hb,
    CRTS_REF_16384K  = 4'hc,
    CRTS_REF_12352K  = 4'hd,
    CRTS_REF_2048K_B = 4'he,
    CRTS_REF_1544K_B = 4'hf
  } crts_ref_sel_t;

  // ----------------------------------------------------------------
  // field encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CRTS_TERM_100 = 2'h0;
  localparam logic [1:0] CRTS_TERM_110 = 2'h1;
  localparam logic [1:0] CRTS_TERM_75  = 2'h2;
  localparam logic [1:0] CRTS_TERM_120 = 2'h3;

  localparam logic [1:0] CRTS_RES_NONE = 2'h0;
  localparam logic [1:0] CRTS_RES_240  = 2'h1;
  localparam logic [1:0] CRTS_RES_210  = 2'h2;
  localparam logic [1:0] CRTS_RES_150  = 2'h3;

  localparam logic [3:0] CRTS_CLKSEL_RST   = 4'h0;
  localparam logic       CRTS_GATING_RST   = 1'b0;
  localparam logic [1:0] CRTS_TERMSEL_RST  = CRTS_TERM_100;
  localparam logic       CRTS_RXTERM_RST   = 1'b0;
  localparam logic       CRTS_OVERRIDE_RST = 1'b0;
  localparam logic [1:0] CRTS_RESSEL_RST   = CRTS_RES_NONE;

  // reference rate in kHz for each selection code (0 never returned)
  function automatic logic [15:0] crts_ref_khz(input logic [3:0] sel);
    logic [15:0] k;
    k = 16'h0800;
    case (sel)
      4'h0, 4'he: k = 16'd2048;
      4'h1, 4'hf: k = 16'd1544;
      4'h2:       k = 16'd8;
      4'h3:       k = 16'd16;
      4'h4:       k = 16'd56;
      4'h5:       k = 16'd64;
      4'h6:       k = 16'd128;
      4'h7:       k = 16'd256;
      4'h8:       k = 16'd4096;
      4'h9:       k = 16'd3088;
      4'ha:       k = 16'd8192;
      4'hb:       k = 16'd6176;
      4'hc:       k = 16'd16384;
      4'hd:       k = 16'd12352;
      default:    k = 16'd2048;
    endcase
    return k;
  endfunction : crts_ref_khz

endpackage : crts_pkg

// ---- crts_clock_term_ctrl.sv ----
// Purpose : clock reference selection, rate-family gating and receive
//           termination control for a multi-channel line interface
// Assumes : one 200 MHz clock; the reference itself is synthesized in analog,
//           this logic produces the selection and enable controls for it
// Notes   : configuration is presented as plain write-enable ports: one for all global fields, one per channel
`timescale 1ns/1ps

// Behaviour
// - codes 0/14 select a 2.048 MHz reference, 1/15 select 1.544 MHz, 2..7 select 8..256 kHz.
// - codes 8..13 select 4.096, 3.088, 8.192, 6.176, 16.384 and 12.352 MHz references.
// - a 1.544 MHz and a 2.048 MHz clock enable is produced for each of the 14 channels.
// - each channel's T1 or E1 rate follows the equalizer rate bit in its own settings.
// - extra output references (8 kHz, T1, E1, multiple T1, multiple E1) are produced.
// - the gating bit resets to 0 (gating active) and writing 1 disables gating.
// - with gating active and T1 configured, all E1 references and the 8 kHz reference stop.
// - with gating active and E1 configured, T1 references stop while 8 kHz keeps running.
// - the 2-bit impedance field selects 100, 110, 75 or 120 ohm for receive and transmit.
// - the per-channel termination enable resets to 0 (high impedance) and 1 applies it.
// - with the override bit at 1 the dedicated pin sets termination for every channel.
// - with the override bit at 0 the pin is ignored and each channel uses its own bit.
// - the per-channel resistor field encodes none, 240, 210 or 150 ohm external resistor.
// - the resistor field resets to the no-resistor code.
module crts_clock_term_ctrl
  import crts_pkg::*;
#(
  parameter int unsigned NUM_CH = CRTS_NUM_CH
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  // global configuration writes
  input  wire logic              i_glb_we,
  input  wire logic [3:0]        i_input_clock_select,
  input  wire logic              i_single_rate_clock_gating,
  input  wire logic              i_termination_pin_override_enable,
  input  wire logic              i_glb_rate_e1,
  // per-channel configuration writes
  input  wire logic [NUM_CH-1:0] i_ch_we,
  input  wire logic [1:0]        i_termination_impedance_select,
  input  wire logic              i_receive_termination_enable,
  input  wire logic [1:0]        i_external_resistor_select,
  input  wire logic              i_ch_rate_e1,
  // dedicated termination pin (asynchronous)
  input  wire logic              i_term_pin,
  // global readback
  output logic [3:0]             o_input_clock_select,
  output logic                   o_single_rate_clock_gating,
  output logic                   o_termination_pin_override_enable,
  output logic                   o_glb_rate_e1,
  output logic [15:0]            o_ref_khz,
  // per-channel readback; impedance and resistor fields packed two bits per channel, the rest one bit
  output logic [2*NUM_CH-1:0]    o_termination_impedance_select,
  output logic [NUM_CH-1:0]      o_receive_termination_enable,
  output logic [2*NUM_CH-1:0]    o_external_resistor_select,
  output logic [NUM_CH-1:0]      o_ch_rate_e1,
  // effective controls
  output logic [NUM_CH-1:0]      o_term_applied,
  output logic [NUM_CH-1:0]      o_ch_t1_clk_en,
  output logic [NUM_CH-1:0]      o_ch_e1_clk_en,
  output logic                   o_ref8k_en,
  output logic                   o_ref_t1_en,
  output logic                   o_ref_e1_en,
  output logic                   o_ref_nt1_en,
  output logic                   o_ref_ne1_en
);

  if (NUM_CH < 1 || NUM_CH > 32) begin : g_chk
    $error("crts_clock_term_ctrl: NUM_CH out of range");
  end

  // ----------------------------------------------------------------
  // global settings
  // ----------------------------------------------------------------
  logic [3:0]  clksel_r,  clksel_nxt;
  logic        gate_r,    gate_nxt;
  logic        ovr_r,     ovr_nxt;
  logic        grate_r,   grate_nxt;
  logic [15:0] khz_r,     khz_nxt;

  always_comb begin
    clksel_nxt = clksel_r;
    gate_nxt   = gate_r;
    ovr_nxt    = ovr_r;
    grate_nxt  = grate_r;
    if (i_glb_we) begin
      clksel_nxt = i_input_clock_select;
      gate_nxt   = i_single_rate_clock_gating;
      ovr_nxt    = i_termination_pin_override_enable;
      grate_nxt  = i_glb_rate_e1;
    end
    khz_nxt = crts_ref_khz(clksel_r);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      clksel_r <= CRTS_CLKSEL_RST;
      gate_r   <= CRTS_GATING_RST;
      ovr_r    <= CRTS_OVERRIDE_RST;
      grate_r  <= 1'b0;
      khz_r    <= crts_ref_khz(CRTS_CLKSEL_RST);
    end else begin
      clksel_r <= clksel_nxt;
      gate_r   <= gate_nxt;
      ovr_r    <= ovr_nxt;
      grate_r  <= grate_nxt;
      khz_r    <= khz_nxt;
    end
  end

  // ----------------------------------------------------------------
  // termination pin synchroniser: change accepted when stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] pin_sync_r, pin_sync_nxt;
  logic       pin_r,      pin_nxt;

  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], i_term_pin};
    pin_nxt      = (pin_sync_r[2] == pin_sync_r[1]) ? pin_sync_r[2] : pin_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pin_sync_r <= 3'h0;
      pin_r      <= 1'b0;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      pin_r      <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-channel settings and outputs
  // ----------------------------------------------------------------
  logic [1:0] tsel_r  [NUM_CH];
  logic [1:0] tsel_nxt[NUM_CH];
  logic [1:0] res_r   [NUM_CH];
  logic [1:0] res_nxt [NUM_CH];
  logic [NUM_CH-1:0] rxt_r, rxt_nxt;
  logic [NUM_CH-1:0] crate_r, crate_nxt;
  logic [NUM_CH-1:0] app_r, app_nxt;
  logic [NUM_CH-1:0] t1en_r, t1en_nxt;
  logic [NUM_CH-1:0] e1en_r, e1en_nxt;

  // gating active stops the family the global rate choice does not use
  logic t1_allowed, e1_allowed;
  always_comb begin
    t1_allowed = gate_r || !grate_r;
    e1_allowed = gate_r ||  grate_r;
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_comb begin
      tsel_nxt[c]  = tsel_r[c];
      res_nxt[c]   = res_r[c];
      rxt_nxt[c]   = rxt_r[c];
      crate_nxt[c] = crate_r[c];
      if (i_ch_we[c]) begin
        tsel_nxt[c]  = i_termination_impedance_select;
        res_nxt[c]   = i_external_resistor_select;
        rxt_nxt[c]   = i_receive_termination_enable;
        crate_nxt[c] = i_ch_rate_e1;
      end
      app_nxt[c]  = ovr_r ? pin_r : rxt_r[c];
      // both rate clocks exist per channel; the channel's own bit picks one
      t1en_nxt[c] = t1_allowed && !crate_r[c];
      e1en_nxt[c] = e1_allowed &&  crate_r[c];
    end

    always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
        tsel_r[c]  <= CRTS_TERMSEL_RST;
        res_r[c]   <= CRTS_RESSEL_RST;
        rxt_r[c]   <= CRTS_RXTERM_RST;
        crate_r[c] <= 1'b0;
        app_r[c]   <= 1'b0;
        t1en_r[c]  <= 1'b0;
        e1en_r[c]  <= 1'b0;
      end else begin
        tsel_r[c]  <= tsel_nxt[c];
        res_r[c]   <= res_nxt[c];
        rxt_r[c]   <= rxt_nxt[c];
        crate_r[c] <= crate_nxt[c];
        app_r[c]   <= app_nxt[c];
        t1en_r[c]  <= t1en_nxt[c];
        e1en_r[c]  <= e1en_nxt[c];
      end
    end

    assign o_termination_impedance_select[2*c +: 2] = tsel_r[c];
    assign o_external_resistor_select[2*c +: 2]     = res_r[c];
  end

  // ----------------------------------------------------------------
  // system output references
  // ----------------------------------------------------------------
  logic r8k_r, r8k_nxt;
  logic rt1_r, rt1_nxt;
  logic re1_r, re1_nxt;

  always_comb begin
    r8k_nxt = gate_r || grate_r;
    rt1_nxt = t1_allowed;
    re1_nxt = e1_allowed;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      r8k_r <= 1'b0;
      rt1_r <= 1'b0;
      re1_r <= 1'b0;
    end else begin
      r8k_r <= r8k_nxt;
      rt1_r <= rt1_nxt;
      re1_r <= re1_nxt;
    end
  end

  assign o_input_clock_select              = clksel_r;
  assign o_single_rate_clock_gating        = gate_r;
  assign o_termination_pin_override_enable = ovr_r;
  assign o_glb_rate_e1                     = grate_r;
  assign o_ref_khz                         = khz_r;
  assign o_receive_termination_enable      = rxt_r;
  assign o_ch_rate_e1                      = crate_r;
  assign o_term_applied                    = app_r;
  assign o_ch_t1_clk_en                    = t1en_r;
  assign o_ch_e1_clk_en                    = e1en_r;
  assign o_ref8k_en                        = r8k_r;
  assign o_ref_t1_en                       = rt1_r;
  assign o_ref_e1_en                       = re1_r;
  // multiples of a rate share that rate's family gating
  assign o_ref_nt1_en                      = rt1_r;
  assign o_ref_ne1_en                      = re1_r;

endmodule : crts_clock_term_ctrl

// ---- crts_monitor.sv ----
// Purpose : port checker for crts_clock_term_ctrl
// Assumes : one clock domain, synchronous active-low reset
// Notes   : derived outputs are judged against last cycle's readback, except the e1 references (against the 8 kHz enable) and the pin override check
`timescale 1ns/1ps
module crts_monitor #(
  parameter int unsigned NUM_CH = 14
) (
  input wire logic              i_ref_clk,
  input wire logic              i_rstn,
  input wire logic              i_glb_we,
  input wire logic [3:0]        i_input_clock_select,
  input wire logic [NUM_CH-1:0] i_ch_we,
  input wire logic              i_receive_termination_enable,
  input wire logic              i_term_pin,
  input wire logic [3:0]        o_input_clock_select,
  input wire logic              o_single_rate_clock_gating,
  input wire logic              o_termination_pin_override_enable,
  input wire logic              o_glb_rate_e1,
  input wire logic [NUM_CH-1:0] o_receive_termination_enable,
  input wire logic [NUM_CH-1:0] o_ch_rate_e1,
  input wire logic [NUM_CH-1:0] o_term_applied,
  input wire logic [NUM_CH-1:0] o_ch_t1_clk_en,
  input wire logic [NUM_CH-1:0] o_ch_e1_clk_en,
  input wire logic              o_ref8k_en,
  input wire logic              o_ref_t1_en,
  input wire logic              o_ref_e1_en,
  input wire logic              o_ref_nt1_en,
  input wire logic              o_ref_ne1_en
);
  // readback is only meaningful two edges after reset is released
  logic [1:0] up_r;
  always_ff @(posedge i_ref_clk) up_r <= {up_r[0], i_rstn};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  chk_glb_readback: assert property (
    i_glb_we |=> o_input_clock_select == $past(i_input_clock_select))
    else $error("global readback wrong");
  chk_ch_readback: assert property (
    i_ch_we[0] |=> o_receive_termination_enable[0] == $past(i_receive_termination_enable))
    else $error("channel readback wrong");
  chk_ref8k_gate: assert property (
    &up_r |-> o_ref8k_en == ($past(o_single_rate_clock_gating) || $past(o_glb_rate_e1)))
    else $error("8k reference enable wrong");
  chk_t1_refs: assert property (
    &up_r |-> o_ref_t1_en == ($past(o_single_rate_clock_gating) || !$past(o_glb_rate_e1))
      && o_ref_nt1_en == o_ref_t1_en)
    else $error("t1 reference enable wrong");
  chk_e1_refs: assert property (
    o_ref_e1_en == o_ref8k_en && o_ref_ne1_en == o_ref8k_en)
    else $error("e1 reference enable wrong");
  chk_ch_e1_en: assert property (
    &up_r |-> o_ch_e1_clk_en == ($past(o_ch_rate_e1)
      & {NUM_CH{$past(o_single_rate_clock_gating) || $past(o_glb_rate_e1)}}))
    else $error("channel e1 enable wrong");
  chk_ch_t1_en: assert property (
    &up_r |-> o_ch_t1_clk_en == (~$past(o_ch_rate_e1)
      & {NUM_CH{$past(o_single_rate_clock_gating) || !$past(o_glb_rate_e1)}}))
    else $error("channel t1 enable wrong");
  chk_term_own_bit: assert property (
    &up_r && !$past(o_termination_pin_override_enable)
      |-> o_term_applied == $past(o_receive_termination_enable))
    else $error("termination from register wrong");
  chk_term_pin_on: assert property (
    (o_termination_pin_override_enable && i_term_pin) [*5] |=> &o_term_applied)
    else $error("pin override did not terminate");
endmodule : crts_monitor

bind crts_clock_term_ctrl crts_monitor #(.NUM_CH(NUM_CH)) u_crts_monitor (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_glb_we(i_glb_we),
  .i_input_clock_select(i_input_clock_select), .i_ch_we(i_ch_we),
  .i_receive_termination_enable(i_receive_termination_enable), .i_term_pin(i_term_pin),
  .o_input_clock_select(o_input_clock_select),
  .o_single_rate_clock_gating(o_single_rate_clock_gating),
  .o_termination_pin_override_enable(o_termination_pin_override_enable),
  .o_glb_rate_e1(o_glb_rate_e1), .o_receive_termination_enable(o_receive_termination_enable),
  .o_ch_rate_e1(o_ch_rate_e1), .o_term_applied(o_term_applied),
  .o_ch_t1_clk_en(o_ch_t1_clk_en), .o_ch_e1_clk_en(o_ch_e1_clk_en),
  .o_ref8k_en(o_ref8k_en), .o_ref_t1_en(o_ref_t1_en), .o_ref_e1_en(o_ref_e1_en),
  .o_ref_nt1_en(o_ref_nt1_en), .o_ref_ne1_en(o_ref_ne1_en));

// ---- crts_clock_term_ctrl_bench.sv ----
// Purpose : self-checking bench for crts_clock_term_ctrl
// Assumes : 200 MHz clock, inputs driven on the falling edge
// Notes   : write tasks wait two edges so derived outputs have settled
`timescale 1ns/1ps
module crts_clock_term_ctrl_bench;
  import crts_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, we = 1'b0, gate = 1'b0, ovr = 1'b0, ge1 = 1'b0;
  logic        rxt = 1'b0, rate = 1'b0, pin = 1'b0, r_gate, r_ovr, r_ge1;
  logic [3:0]  sel = 4'h0, r_sel;
  logic [13:0] chwe = 14'h0, r_rxt, r_rate, term, t1en, e1en;
  logic [1:0]  tsel = 2'h0, res = 2'h0;
  logic [15:0] khz;
  logic [27:0] r_tsel, r_res;
  logic        r8k, rt1, re1, rnt1, rne1;
  int          errors = 0, n_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  crts_clock_term_ctrl u_crts_clock_term_ctrl (.i_ref_clk(clk), .i_rstn(rstn),
    .i_glb_we(we), .i_input_clock_select(sel), .i_single_rate_clock_gating(gate),
    .i_termination_pin_override_enable(ovr), .i_glb_rate_e1(ge1), .i_ch_we(chwe),
    .i_termination_impedance_select(tsel), .i_receive_termination_enable(rxt),
    .i_external_resistor_select(res), .i_ch_rate_e1(rate), .i_term_pin(pin),
    .o_input_clock_select(r_sel), .o_single_rate_clock_gating(r_gate),
    .o_termination_pin_override_enable(r_ovr), .o_glb_rate_e1(r_ge1), .o_ref_khz(khz),
    .o_termination_impedance_select(r_tsel), .o_receive_termination_enable(r_rxt),
    .o_external_resistor_select(r_res), .o_ch_rate_e1(r_rate), .o_term_applied(term),
    .o_ch_t1_clk_en(t1en), .o_ch_e1_clk_en(e1en), .o_ref8k_en(r8k), .o_ref_t1_en(rt1),
    .o_ref_e1_en(re1), .o_ref_nt1_en(rnt1), .o_ref_ne1_en(rne1));
  task automatic tally_and_finish();
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic gw(input logic [3:0] s, input logic g, input logic o, input logic e);
    @(negedge clk);
    {we, sel, gate, ovr, ge1} = {1'b1, s, g, o, e};
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask : gw
  task automatic cw(input logic [13:0] m, input logic [1:0] t, input logic r,
                    input logic [1:0] x, input logic e);
    @(negedge clk);
    {chwe, tsel, rxt, res, rate} = {m, t, r, x, e};
    @(negedge clk);
    chwe = 14'h0;
    @(negedge clk);
  endtask : cw
  task automatic t_reset();
    chk("clock select", r_sel, 4'h0);
    chk("gating", r_gate, 1'b0);
    chk("rx term", r_rxt, 14'h0);
    chk("resistor", r_res, 28'h0);
    chk("ref khz", khz, 16'h0800);
    chk("8k ref", r8k, 1'b0);
    chk("t1 ref", rt1, 1'b1);
    chk("override", r_ovr, 1'b0);
    chk("glb e1", r_ge1, 1'b0);
  endtask : t_reset
  task automatic t_codes();
    logic [15:0] k [16];
    k = '{16'h0800, 16'h0608, 16'h0008, 16'h0010, 16'h0038, 16'h0040, 16'h0080,
          16'h0100, 16'h1000, 16'h0c10, 16'h2000, 16'h1820, 16'h4000, 16'h3040,
          16'h0800, 16'h0608};
    for (int i = 0; i < 16; i++) begin
      gw(i[3:0], 1'b0, 1'b0, 1'b0);
      chk("clock select", r_sel, i[3:0]);
      chk("ref khz", khz, k[i]);
    end
  endtask : t_codes
  task automatic t_gating();
    for (int i = 0; i < 4; i++) begin
      gw(4'h0, i[1], 1'b0, i[0]);
      chk("8k ref", r8k, i[1] | i[0]);
      chk("e1 ref", re1, i[1] | i[0]);
      chk("ne1 ref", rne1, i[1] | i[0]);
      chk("t1 ref", rt1, i[1] | !i[0]);
      chk("nt1 ref", rnt1, i[1] | !i[0]);
      chk("glb e1", r_ge1, i[0]);
      chk("gating", r_gate, i[1]);
    end
  endtask : t_gating
  task automatic t_channels();
    cw(14'h1555, CRTS_TERM_120, 1'b1, CRTS_RES_210, 1'b1);
    cw(14'h2aaa, CRTS_TERM_75, 1'b0, CRTS_RES_240, 1'b0);
    chk("impedance", r_tsel, 28'hbbbbbbb);
    chk("resistor", r_res, 28'h6666666);
    chk("rx term", r_rxt, 14'h1555);
    chk("rate", r_rate, 14'h1555);
    gw(4'h0, 1'b1, 1'b0, 1'b0);
    chk("ch e1", e1en, 14'h1555);
    chk("ch t1", t1en, 14'h2aaa);
    gw(4'h0, 1'b0, 1'b0, 1'b1);
    chk("ch t1 gated", t1en, 14'h0);
    chk("ch e1 kept", e1en, 14'h1555);
    chk("term", term, 14'h1555);
    gw(4'h0, 1'b0, 1'b0, 1'b0);
    chk("ch e1 gated", e1en, 14'h0);
    chk("ch t1 kept", t1en, 14'h2aaa);
    // one channel rewritten with the remaining codes; the others must hold
    cw(14'h0001, CRTS_TERM_110, 1'b1, CRTS_RES_150, 1'b1);
    chk("impedance", r_tsel, 28'hbbbbbb9);
    chk("resistor", r_res, 28'h6666667);
    chk("rx term", r_rxt, 14'h1555);
  endtask : t_channels
  task automatic t_pin();
    gw(4'h0, 1'b1, 1'b1, 1'b0);
    chk("override", r_ovr, 1'b1);
    pin = 1'b1;
    repeat (5) @(negedge clk);
    chk("term pin hi", term, 14'h3fff);
    pin = 1'b0;
    repeat (5) @(negedge clk);
    chk("term pin lo", term, 14'h0);
    pin = 1'b1;
    gw(4'h0, 1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    chk("term own", term, 14'h1555);
  endtask : t_pin
  // mid-run reset must drop every written setting back to its reset value
  task automatic t_rerun();
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    chk("impedance", r_tsel, 28'h0);
    chk("rate", r_rate, 14'h0);
    chk("term", term, 14'h0);
  endtask : t_rerun
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_codes();
    t_gating();
    t_channels();
    t_pin();
    t_rerun();
    tally_and_finish();
  end
endmodule : crts_clock_term_ctrl_bench
